// >>> common/sid_defs.svh
/*
  Constants of the identification-page access block: opcodes, address
  fields, reset values and write-cycle timing.
  Assumes a 100 MHz core clock and an SPI master in mode 0.
*/
`ifndef SID_DEFS_SVH
`define SID_DEFS_SVH

`define SID_OPC_ID_WRITE 8'h82
`define SID_OPC_LOCK_READ 8'h83
`define SID_OPC_ID_READ 8'h8A
`define SID_OPC_WRITE_ARM 8'h0A
`define SID_ADDR_SEL_BIT 2
`define SID_LOCK_DATA_BIT 1
`define SID_GUARD_ALL 2'h3
`define SID_ID_BYTE0 8'h5A
`define SID_ID_BYTE1 8'hA5
`define SID_ID_BYTE2 8'h3C
`define SID_BLANK 8'hFF
`define SID_CLK_NS 10
`define SID_WCYC_NS 5000000
`define SID_WCYC_CYC ((`SID_WCYC_NS + `SID_CLK_NS - 1) / `SID_CLK_NS)

`endif

// >>> common/sid_pkg.sv
/*
  Types of the identification-page access block.
  Assumes sid_defs.svh supplies the numeric constants.
*/
package sid_pkg;
  typedef enum logic [2:0] {PH_OPC, PH_ADDR, PH_DIN, PH_DOUT, PH_ARM, PH_IGN} sid_phase_e;
  typedef enum logic {K_PAGE, K_LOCK} sid_kind_e;
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } sid_pins_s;
  typedef struct packed {
    sid_pins_s s1;
    sid_pins_s s2;
    logic sck_d;
    logic cs_d;
    sid_phase_e phase;
    sid_kind_e kind;
    logic is_write;
    logic [2:0] bitcnt;
    logic addr_hi_done;
    logic [7:0] opc;
    logic [7:0] rx;
    logic [7:0] addr_hi;
    logic [4:0] ptr;
    logic got;
    logic lock_req;
    logic [7:0] tx;
    logic [2:0] txcnt;
    logic so_bit;
    logic so_oe;
    logic armed;
    logic busy;
    logic [23:0] wcnt;
    logic commit_lock;
    logic [31:0] mask;
    logic [31:0][7:0] stage;
    logic [31:0][7:0] page;
    logic locked;
  } sid_state_s;
endpackage : sid_pkg

// >>> hdl/sid_obuf.sv
/*
  Two-entry buffer between the byte fetcher and the output shifter.
  Assumes one clock and a synchronous flush from the owner.
*/
`timescale 1ns/1ps
`default_nettype none
module sid_obuf #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } sid_buf_s;

  sid_buf_s r;
  sid_buf_s n;
  logic do_push;
  logic do_pop;

  assign in_ready = (r.cnt != 2'h2);
  assign out_valid = (r.cnt != 2'h0);
  assign out_data = r.mem[r.rp];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always_comb begin
    n = r;
    if (flush) begin
      n.wp = 1'b0;
      n.rp = 1'b0;
      n.cnt = 2'h0;
    end else begin
      if (do_push) begin
        n.mem[r.wp] = in_data;
        n.wp = ~r.wp;
      end
      if (do_pop) begin
        n.rp = ~r.rp;
      end
      n.cnt = r.cnt + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule : sid_obuf
`default_nettype wire

// >>> hdl/sid_top.sv
/*
  Identification-page engine of a serial EEPROM: command decode, page
  read and write, lock status read, page lock and the timed write cycle.
  Assumes pins arrive asynchronous to ref_clk, SPI mode 0, and a link
  clock far slower than ref_clk so each edge is seen on its own.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sid_defs.svh"
module sid_top
  import sid_pkg::*;
#(
  parameter logic [7:0] ID_READ_OPC = `SID_OPC_ID_READ,
  parameter logic [7:0] WRITE_ARM_OPC = `SID_OPC_WRITE_ARM,
  parameter int WCYC = `SID_WCYC_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic block_guard_hi,
  input wire logic block_guard_lo,
  output logic busy_flag,
  output logic write_latch_bit,
  output logic page_locked
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_q;
  logic rst_n;

  // Commands are answered only once the clear has left the chain
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  sid_state_s r;
  sid_state_s n;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic selected;
  logic [7:0] byte_in;
  logic byte_done;
  logic [1:0] guard;
  logic push_valid;
  logic push_ready;
  logic [7:0] push_data;
  logic pop;
  logic buf_valid;
  logic [7:0] buf_data;
  logic buf_flush;

  assign selected = !r.s2.cs_n;
  assign sck_rise = r.s2.sck && !r.sck_d;
  assign sck_fall = !r.s2.sck && r.sck_d;
  assign cs_fall = !r.s2.cs_n && r.cs_d;
  assign cs_rise = r.s2.cs_n && !r.cs_d;
  assign byte_in = {r.rx[6:0], r.s2.si};
  assign byte_done = selected && !cs_fall && sck_rise && (r.bitcnt == 3'h7);
  assign guard = {block_guard_hi, block_guard_lo};

  // ----------------------------------------------------------------
  // Prefetch into the output buffer
  // ----------------------------------------------------------------
  // Keeps a byte ready before the first falling edge of each byte slot
  assign push_valid = (r.phase == PH_DOUT) && selected;
  assign push_data = (r.kind == K_LOCK) ? {7'h00, r.locked} : r.page[r.ptr];
  assign buf_flush = (r.phase != PH_DOUT);

  sid_obuf #(
    .W(8)
  ) u_obuf (
    .clk(ref_clk),
    .rst_n(rst_n),
    .flush(buf_flush),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(buf_valid),
    .out_ready(pop),
    .out_data(buf_data)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    pop = 1'b0;
    n.s1 = {cs_n, sck, si};
    n.s2 = r.s1;
    n.sck_d = r.s2.sck;
    n.cs_d = r.s2.cs_n;

    // Timed write cycle; commit only at its end
    if (r.busy) begin
      if (r.wcnt <= 24'h1) begin
        n.busy = 1'b0;
        n.mask = '0;
        if (r.commit_lock) begin
          n.locked = 1'b1;
        end else if (!r.locked) begin
          for (int i = 0; i < 32; i++) begin
            if (r.mask[i]) begin
              n.page[i] = r.stage[i];
            end
          end
        end
      end else begin
        n.wcnt = r.wcnt - 24'h1;
      end
    end

    if (cs_fall) begin
      n.phase = PH_OPC;
      n.bitcnt = 3'h0;
      n.addr_hi_done = 1'b0;
      n.got = 1'b0;
      n.lock_req = 1'b0;
      // Staged bytes wait for the running cycle; a new frame must not wipe them
      if (!r.busy) begin
        n.mask = '0;
      end
      n.txcnt = 3'h0;
    end else if (cs_rise) begin
      n.so_oe = 1'b0;
      if (r.phase == PH_ARM && r.bitcnt == 3'h0) begin
        n.armed = 1'b1;
      end
      // Only a full data byte counts; a partial byte drops the command
      if (r.phase == PH_DIN && r.got && r.bitcnt == 3'h0 && !r.busy) begin
        if (r.kind == K_PAGE || r.lock_req) begin
          n.busy = 1'b1;
          n.wcnt = WCYC[23:0];
          n.commit_lock = (r.kind == K_LOCK);
          n.armed = 1'b0;
        end
      end
      n.phase = PH_IGN;
    end else if (selected && sck_rise) begin
      n.rx = byte_in;
      n.bitcnt = r.bitcnt + 3'h1;
      if (r.phase == PH_ARM) begin
        n.phase = PH_IGN;
      end else if (r.bitcnt == 3'h7) begin
        case (r.phase)
          PH_OPC: begin
            n.opc = byte_in;
            n.is_write = 1'b0;
            if (byte_in == ID_READ_OPC || byte_in == `SID_OPC_LOCK_READ) begin
              n.phase = r.busy ? PH_IGN : PH_ADDR;
            end else if (byte_in == `SID_OPC_ID_WRITE) begin
              n.is_write = 1'b1;
              if (r.busy || guard == `SID_GUARD_ALL || !r.armed) begin
                n.phase = PH_IGN;
              end else begin
                n.phase = PH_ADDR;
              end
            end else if (byte_in == WRITE_ARM_OPC) begin
              n.phase = PH_ARM;
            end else begin
              n.phase = PH_IGN;
            end
          end
          PH_ADDR: begin
            if (!r.addr_hi_done) begin
              n.addr_hi = byte_in;
              n.addr_hi_done = 1'b1;
            end else begin
              n.ptr = byte_in[4:0];
              if (r.is_write) begin
                n.kind = r.addr_hi[`SID_ADDR_SEL_BIT] ? K_LOCK : K_PAGE;
                n.phase = PH_DIN;
              end else if (r.opc == `SID_OPC_LOCK_READ) begin
                n.kind = K_LOCK;
                n.phase = r.addr_hi[`SID_ADDR_SEL_BIT] ? PH_DOUT : PH_IGN;
              end else begin
                n.kind = K_PAGE;
                n.phase = r.addr_hi[`SID_ADDR_SEL_BIT] ? PH_IGN : PH_DOUT;
              end
            end
          end
          PH_DIN: begin
            n.got = 1'b1;
            if (r.kind == K_PAGE) begin
              n.stage[r.ptr] = byte_in;
              n.mask[r.ptr] = 1'b1;
              n.ptr = r.ptr + 5'h1;
            end else begin
              n.lock_req = byte_in[`SID_LOCK_DATA_BIT];
            end
          end
          default: begin
          end
        endcase
      end
    end else if (selected && sck_fall && r.phase == PH_DOUT) begin
      n.so_oe = 1'b1;
      if (r.txcnt == 3'h0) begin
        pop = buf_valid;
        n.so_bit = buf_data[7];
        n.tx = {buf_data[6:0], 1'b0};
        n.txcnt = 3'h7;
      end else begin
        n.so_bit = r.tx[7];
        n.tx = {r.tx[6:0], 1'b0};
        n.txcnt = r.txcnt - 3'h1;
      end
    end

    // Page reads walk the pointer; lock reads repeat the status byte
    if (push_valid && push_ready && r.kind == K_PAGE) begin
      n.ptr = r.ptr + 5'h1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.s1 <= 3'h4;
      r.s2 <= 3'h4;
      r.cs_d <= 1'b1;
      r.phase <= PH_IGN;
      r.page <= {{29{`SID_BLANK}}, `SID_ID_BYTE2, `SID_ID_BYTE1, `SID_ID_BYTE0};
    end else begin
      r <= n;
    end
  end

  assign so = r.so_bit;
  assign so_oe = r.so_oe;
  assign busy_flag = r.busy;
  assign write_latch_bit = r.armed;
  assign page_locked = r.locked;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_out_needs_select: assert property (so_oe |-> (!r.cs_d || !r.s2.cs_n))
    else $error("serial output driven while deselected");

  a_out_stops_on_end: assert property (cs_rise |=> !so_oe)
    else $error("serial output still driven after deselect");

  a_read_busy_ignored: assert property (
    (byte_done && r.phase == PH_OPC && r.busy && byte_in == ID_READ_OPC)
    |=> r.phase == PH_IGN)
    else $error("page read accepted during write cycle");

  a_lock_rd_busy: assert property (
    (byte_done && r.phase == PH_OPC && r.busy && byte_in == `SID_OPC_LOCK_READ)
    |=> r.phase == PH_IGN)
    else $error("lock status read accepted during write cycle");

  a_write_guard_drop: assert property (
    (byte_done && r.phase == PH_OPC && byte_in == `SID_OPC_ID_WRITE
     && (guard == `SID_GUARD_ALL || !r.armed))
    |=> r.phase == PH_IGN)
    else $error("guarded or unarmed write accepted");

  a_cycle_start_len: assert property (
    $rose(r.busy) |-> r.wcnt == WCYC[23:0] && $past(r.armed) && !r.armed)
    else $error("write cycle started wrongly");

  a_busy_count: assert property (
    (r.busy && r.wcnt > 24'h1) |=> r.busy && r.wcnt == $past(r.wcnt) - 24'h1)
    else $error("write cycle count skipped");

  a_mask_held: assert property (
    (r.busy && r.wcnt > 24'h1) |=> r.mask == $past(r.mask))
    else $error("staged bytes lost during write cycle");

  a_partial_byte_drop: assert property (
    (cs_rise && r.bitcnt != 3'h0) |=> !$rose(r.busy))
    else $error("command run on partial byte");

  a_lock_needs_bit: assert property (
    (cs_rise && r.phase == PH_DIN && r.kind == K_LOCK && !r.lock_req)
    |=> !$rose(r.busy))
    else $error("lock started without lock bit");

  a_lock_from_cycle: assert property (
    $rose(r.locked) |-> $past(r.busy) && $past(r.commit_lock) && !r.busy)
    else $error("lock set outside its write cycle");

  a_lock_sticky: assert property (r.locked |=> r.locked)
    else $error("page lock released");

  a_page_frozen: assert property (r.locked |=> r.page == $past(r.page))
    else $error("locked page changed");

  a_lock_byte: assert property (
    (pop && r.kind == K_LOCK) |-> buf_data == {7'h00, r.locked})
    else $error("lock status byte wrong");

  a_addr_sel_lock: assert property (
    (byte_done && r.phase == PH_ADDR && r.addr_hi_done && r.opc == `SID_OPC_LOCK_READ
     && !r.addr_hi[`SID_ADDR_SEL_BIT]) |=> r.phase == PH_IGN)
    else $error("lock status read taken with select bit clear");

  a_addr_sel_page: assert property (
    (byte_done && r.phase == PH_ADDR && r.addr_hi_done && !r.is_write
     && r.opc == ID_READ_OPC && r.addr_hi[`SID_ADDR_SEL_BIT]) |=> r.phase == PH_IGN)
    else $error("page read taken with select bit set");

  a_lock_repeat: assert property (
    (r.phase == PH_DOUT && r.kind == K_LOCK) |=> r.ptr == $past(r.ptr))
    else $error("lock status read moved the address");

  a_read_advance: assert property (
    (push_valid && push_ready && r.kind == K_PAGE) |=> r.ptr == $past(r.ptr) + 5'h1)
    else $error("page read pointer did not advance");

  a_out_byte_ready: assert property (
    (selected && sck_fall && r.phase == PH_DOUT && r.txcnt == 3'h0) |-> buf_valid)
    else $error("no byte ready at byte slot start");

  a_oe_from_read: assert property ($rose(so_oe) |-> $past(r.phase) == PH_DOUT)
    else $error("serial output enabled outside a read");

endmodule : sid_top
`default_nettype wire

// >>> tb/sid_spi_master.sv
/*
  SPI master model for the id-page bench: mode 0 frames, byte capture.
  Assumes the bench calls frame and listens to the got event.
*/
`timescale 1ns/1ps
`default_nettype none
module sid_spi_master (
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic [7:0] rx_byte;
  logic rx_oe;
  event got;

  // Idle deselected, clock stands still between frames
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // --------------------------------------------------
  // Frame
  // --------------------------------------------------
  // Own delays on purpose: link clock unrelated to ref_clk
  task automatic frame(input logic [7:0] b[$], input int nb, input bit rd);
    logic [7:0] sh;
    logic oe;
    #3.1 cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      si = (i / 8 < b.size()) ? b[i / 8][7 - i % 8] : ~si;
      #62.5 sck = 1'b1;
      sh = {sh[6:0], so & so_oe};
      oe = (i % 8 == 0) ? so_oe : oe & so_oe;
      if (rd && i >= 24 && i % 8 == 7) begin
        rx_byte = sh;
        rx_oe = oe;
        -> got;
      end
      #62.5 sck = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    si = ~si;
    #125;
  endtask : frame
endmodule : sid_spi_master
`default_nettype wire

// >>> tb/sid_top_test.sv
/*
  Self-checking bench of the id-page engine with an SPI master model.
  Assumes sid_defs.svh constants and a shortened write cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sid_defs.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
  $display("BAD %s exp %0h got %0h", n, e, g); n_mismatch++; end end
module sid_top_test;
  import sid_pkg::*;
  localparam int WCYC = 200;
  logic ref_clk, arst_n, cs_n, sck, si, so, so_oe;
  logic block_guard_hi, block_guard_lo, busy_flag, write_latch_bit, page_locked;
  int n_mismatch, n_checks;
  logic [8:0] expq[$];
  logic [7:0] img[32];
  logic [7:0] x, y;
  logic lk;
  int s;

  sid_top #(.WCYC(WCYC)) sid_top_i (.ref_clk(ref_clk), .arst_n(arst_n), .cs_n(cs_n),
    .sck(sck), .si(si), .so(so), .so_oe(so_oe), .block_guard_hi(block_guard_hi),
    .block_guard_lo(block_guard_lo), .busy_flag(busy_flag),
    .write_latch_bit(write_latch_bit), .page_locked(page_locked));
  sid_spi_master sid_spi_master_i (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // --------------------------------------------------
  // Tasks
  // --------------------------------------------------
  task automatic close_out;
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  task automatic send(input logic [7:0] b[$], input int nb, input bit rd);
    sid_spi_master_i.frame(b, nb, rd);
    repeat (8) @(posedge ref_clk);
    `CHK("so_oe", 1'b0, so_oe)
  endtask : send

  task automatic init_img;
    for (int k = 0; k < 32; k++) img[k] = `SID_BLANK;
    img[0] = `SID_ID_BYTE0;
    img[1] = `SID_ID_BYTE1;
    img[2] = `SID_ID_BYTE2;
    lk = 1'b0;
  endtask : init_img

  // Stops inside the page since no wrap is promised
  task automatic rd_page(input int st, input int n, input bit ok, input int ext);
    for (int k = 0; k < n; k++) expq.push_back(ok ? {1'b1, img[st + k]} : 9'h000);
    send('{`SID_OPC_ID_READ, 8'($urandom) & 8'hFB, {3'($urandom), 5'(st)}},
      24 + 8 * n + ext, 1'b1);
  endtask : rd_page

  task automatic rd_lock(input int n, input bit ok);
    for (int k = 0; k < n; k++) expq.push_back(ok ? {1'b1, 7'h00, lk} : 9'h000);
    send('{`SID_OPC_LOCK_READ, 8'($urandom) | 8'h04, 8'($urandom)}, 24 + 8 * n, 1'b1);
  endtask : rd_lock

  task automatic arm;
    send('{`SID_OPC_WRITE_ARM}, 8, 1'b0);
    `CHK("write_latch_bit", 1'b1, write_latch_bit)
  endtask : arm

  task automatic wr(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] d,
    input int nb, input bit acc);
    arm();
    send('{`SID_OPC_ID_WRITE, hi, lo, d}, nb, 1'b0);
    `CHK("busy_flag", acc, busy_flag)
    `CHK("write_latch_bit", !acc, write_latch_bit)
  endtask : wr

  task automatic wait_idle;
    for (int k = 0; k < 2 * WCYC && busy_flag !== 1'b0; k++) @(posedge ref_clk);
    `CHK("busy_flag", 1'b0, busy_flag)
  endtask : wait_idle

  // --------------------------------------------------
  // Result watcher
  // --------------------------------------------------
  initial begin
    logic [8:0] e;
    forever begin
      @(sid_spi_master_i.got);
      e = (expq.size() > 0) ? expq.pop_front() : 9'h1FF;
      `CHK("read byte", e, {sid_spi_master_i.rx_oe, sid_spi_master_i.rx_byte})
    end
  end

  initial begin
    #800us;
    n_mismatch++;
    close_out();
  end

  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial begin
    arst_n = 1'b0;
    block_guard_hi = 1'b0;
    block_guard_lo = 1'b0;
    s = $urandom(32'hA497);
    init_img();
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    `CHK("busy_flag", 1'b0, busy_flag)
    `CHK("write_latch_bit", 1'b0, write_latch_bit)
    rd_page(0, 32, 1'b1, 0);
    s = $urandom_range(31, 1);
    rd_page(s, 32 - s, 1'b1, 5);
    rd_lock(3, 1'b1);
    expq.push_back(9'h000);
    send('{`SID_OPC_LOCK_READ, 8'h00, 8'h00}, 32, 1'b1);
    expq.push_back(9'h000);
    send('{`SID_OPC_ID_READ, 8'h04, 8'h00}, 32, 1'b1);
    send('{`SID_OPC_ID_WRITE, 8'h00, 8'h05, 8'h00}, 32, 1'b0);
    `CHK("busy_flag", 1'b0, busy_flag)
    x = 8'($urandom);
    y = 8'($urandom);
    arm();
    send('{`SID_OPC_ID_WRITE, 8'h00, 8'h01, x, y}, 40, 1'b0);
    `CHK("busy_flag", 1'b1, busy_flag)
    rd_page(0, 2, 1'b0, 0);
    wait_idle();
    img[1] = x;
    img[2] = y;
    rd_page(0, 4, 1'b1, 0);
    for (int g = 0; g < 4; g++) begin
      @(posedge ref_clk);
      {block_guard_hi, block_guard_lo} <= 2'(g);
      x = 8'($urandom);
      @(posedge ref_clk);
      wr(8'($urandom) & 8'hFB, 8'h06, x, 32, g != 3);
      if (g != 3) begin
        wait_idle();
        img[6] = x;
      end
    end
    wr(8'h04, 8'h00, 8'h02, 32, 1'b0);
    @(posedge ref_clk);
    {block_guard_hi, block_guard_lo} <= 2'h0;
    rd_page(5, 3, 1'b1, 0);
    wr(8'h04, 8'h00, 8'h02, 36, 1'b0);
    wr(8'h04, 8'h00, 8'hFD, 32, 1'b0);
    wr(8'($urandom) | 8'h04, 8'($urandom), 8'($urandom) | 8'h02, 32, 1'b1);
    rd_lock(1, 1'b0);
    wait_idle();
    lk = 1'b1;
    `CHK("page_locked", 1'b1, page_locked)
    rd_lock(4, 1'b1);
    wr(8'h00, 8'h06, 8'h00, 32, 1'b1);
    wait_idle();
    rd_page(5, 3, 1'b1, 0);
    // Second reset mid-run: frame during clear must stay silent
    @(posedge ref_clk);
    arst_n <= 1'b0;
    rd_lock(2, 1'b0);
    @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    init_img();
    `CHK("page_locked", 1'b0, page_locked)
    rd_page(0, 7, 1'b1, 0);
    `CHK("queue left", 0, expq.size())
    close_out();
  end
endmodule : sid_top_test
`default_nettype wire
